/* inc/mtpcs_map.vh */
// Purpose: constants for the EPROM command-mode host controller
// Assumes: 200 MHz ref_clk, 5 ns period
// Notes: times kept in their own units, cycle counts derived from them
`ifndef MTPCS_MAP_VH
`define MTPCS_MAP_VH

`define MTPCS_CLK_MHZ 200
`define MTPCS_CMD_READ 8'h00
`define MTPCS_CMD_ERASE 8'h20
`define MTPCS_CMD_EVERIFY 8'ha0
`define MTPCS_CMD_PROG 8'h40
`define MTPCS_CMD_PVERIFY 8'hc0
`define MTPCS_CMD_RESET 8'hff

// host operation codes
`define MTPCS_OP_READMODE 3'h0
`define MTPCS_OP_ERASE 3'h1
`define MTPCS_OP_EVERIFY 3'h2
`define MTPCS_OP_PROG 3'h3
`define MTPCS_OP_PVERIFY 3'h4
`define MTPCS_OP_RESET 3'h5
`define MTPCS_OP_ARRAYRD 3'h6

// times in ns / us / ms
`define MTPCS_T_WP_NS 50
`define MTPCS_T_WPH_NS 20
`define MTPCS_T_AH_NS 40
`define MTPCS_T_DH_NS 10
`define MTPCS_T_ACC_NS 150
`define MTPCS_T_VPEL_US 1
`define MTPCS_T_WR_US 6
`define MTPCS_T_PROG_US 10
`define MTPCS_T_ERASE_MS 100

// cycle counts at 5 ns, least times rounded up, sized to the counter
`define MTPCS_C_WP 25'ha
`define MTPCS_C_WPH 25'h4
`define MTPCS_C_DH 25'h2
`define MTPCS_C_ACC 25'h1e
`define MTPCS_C_VPEL 25'hc8
`define MTPCS_C_WR 25'h4b0
`define MTPCS_C_PROG 25'h7d0
`define MTPCS_C_ERASE 25'h1312d00
// read window: access time plus two sync stages and two cycles margin
`define MTPCS_C_RDWIN 25'h22

`define MTPCS_CNT_W 25
`define MTPCS_ADDR_W 18
`define MTPCS_DATA_W 8

`endif

/* logic/mtpcs_pin_sync.v */
// Purpose: two-stage synchroniser for the read-back data pins
// Assumes: data pins are asynchronous to ref_clk
// Notes: first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module mtpcs_pin_sync #(
	parameter W = 8
) (
	input wire ref_clk,
	input wire nrst,
	input wire [W-1:0] pinIn,
	output reg [W-1:0] pinOut
);
	reg [W-1:0] meta_reg;

	always @(posedge ref_clk) begin
		if (!nrst) begin
			meta_reg <= {W{1'b0}};
			pinOut <= {W{1'b0}};
		end else begin
			meta_reg <= pinIn;
			pinOut <= meta_reg;
		end
	end
endmodule // mtpcs_pin_sync
`default_nettype wire

/* logic/mtpcs_host.v */
// Purpose: host that drives an EPROM in command mode over its pins
// Assumes: 200 MHz ref_clk; one operation at a time via opStart/opBusy
// Notes: erase, program and write-recovery wait counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
`include "mtpcs_map.vh"
module mtpcs_host #(
	parameter [24:0] ERASE_CYC = `MTPCS_C_ERASE,
	parameter [24:0] PROG_CYC = `MTPCS_C_PROG,
	parameter [24:0] WR_CYC = `MTPCS_C_WR
) (
	input wire ref_clk,
	input wire nrst,
	input wire opStart,
	input wire [2:0] opCode,
	input wire [17:0] opAddr,
	input wire [7:0] opData,
	output reg opBusy,
	output reg opDone,
	output reg [7:0] opResult,
	output reg [17:0] addressBus,
	output reg [7:0] dataBusOut,
	output reg dataBusOe,
	input wire [7:0] dataBusIn,
	output reg chipEn_n,
	output reg outEn_n,
	output reg writeEn_n,
	output reg highVoltageLevel
);
	// ---------------------------------------------------------------
	// states
	// ---------------------------------------------------------------
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_VPP = 4'h1;
	localparam [3:0] S_WLOW = 4'h2;
	localparam [3:0] S_WHIGH = 4'h3;
	localparam [3:0] S_HOLD = 4'h4;
	localparam [3:0] S_WAIT = 4'h5;
	localparam [3:0] S_RLOW = 4'h6;
	localparam [3:0] S_FINISH = 4'h7;

	reg [3:0] state_reg, state_next;
	reg [24:0] cnt_reg, cnt_next;
	reg [1:0] step_reg, step_next;
	reg [2:0] op_reg, op_next;
	reg [17:0] addr_reg, addr_next;
	reg [7:0] data_reg, data_next;
	reg [7:0] cmdByte;
	reg [17:0] cycAddr;
	reg lastWrite;
	reg doRead;
	reg [24:0] waitCyc;
	wire [7:0] dataSync;

	mtpcs_pin_sync #(.W(`MTPCS_DATA_W)) uSync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.pinIn(dataBusIn),
		.pinOut(dataSync)
	);

	// ---------------------------------------------------------------
	// per-step bus cycle content
	// ---------------------------------------------------------------
	always @* begin
		cmdByte = `MTPCS_CMD_READ;
		cycAddr = {`MTPCS_ADDR_W{1'b0}};
		lastWrite = 1'b1;
		doRead = 1'b0;
		waitCyc = WR_CYC;
		case (op_reg)
		`MTPCS_OP_READMODE: begin
			cmdByte = `MTPCS_CMD_READ;
			// a plain read may follow at once, keep the recovery floor
			waitCyc = WR_CYC;
		end
		`MTPCS_OP_ERASE: begin
			cmdByte = `MTPCS_CMD_ERASE;
			lastWrite = (step_reg == 2'h1);
			waitCyc = ERASE_CYC;
		end
		`MTPCS_OP_EVERIFY: begin
			// address goes with the command itself
			cmdByte = `MTPCS_CMD_EVERIFY;
			cycAddr = addr_reg;
			doRead = 1'b1;
		end
		`MTPCS_OP_PROG: begin
			lastWrite = (step_reg == 2'h1);
			cmdByte = lastWrite ? data_reg : `MTPCS_CMD_PROG;
			cycAddr = lastWrite ? addr_reg : {`MTPCS_ADDR_W{1'b0}};
			waitCyc = PROG_CYC;
		end
		`MTPCS_OP_PVERIFY: begin
			// device reads back its own latched program address
			cmdByte = `MTPCS_CMD_PVERIFY;
			doRead = 1'b1;
		end
		`MTPCS_OP_RESET: begin
			cmdByte = `MTPCS_CMD_RESET;
			lastWrite = (step_reg == 2'h1);
			waitCyc = WR_CYC;
		end
		`MTPCS_OP_ARRAYRD: begin
			cycAddr = addr_reg;
			lastWrite = 1'b0;
			doRead = 1'b1;
		end
		default: begin
			waitCyc = 25'h1;
		end
		endcase
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		step_next = step_reg;
		op_next = op_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		case (state_reg)
		S_IDLE: begin
			if (opStart && opCode <= `MTPCS_OP_ARRAYRD) begin
				op_next = opCode;
				addr_next = opAddr;
				data_next = opData;
				step_next = 2'h0;
				cnt_next = `MTPCS_C_VPEL;
				state_next = S_VPP;
			end
		end
		S_VPP: begin
			if (cnt_reg > 25'h1) begin
				cnt_next = cnt_reg - 25'h1;
			end else if (op_reg == `MTPCS_OP_ARRAYRD) begin
				cnt_next = `MTPCS_C_RDWIN;
				state_next = S_RLOW;
			end else begin
				cnt_next = `MTPCS_C_WP;
				state_next = S_WLOW;
			end
		end
		S_WLOW: begin
			if (cnt_reg > 25'h1) begin
				cnt_next = cnt_reg - 25'h1;
			end else begin
				// data held past the strobe rise
				cnt_next = `MTPCS_C_DH;
				state_next = S_HOLD;
			end
		end
		S_HOLD: begin
			if (cnt_reg > 25'h1) begin
				cnt_next = cnt_reg - 25'h1;
			end else if (!lastWrite) begin
				step_next = 2'h1;
				cnt_next = `MTPCS_C_WPH;
				state_next = S_WHIGH;
			end else begin
				// verify reads wait the WR_CYC floor, other ops wait their own waitCyc
				cnt_next = doRead ? WR_CYC : waitCyc;
				state_next = S_WAIT;
			end
		end
		S_WHIGH: begin
			if (cnt_reg > 25'h1) begin
				cnt_next = cnt_reg - 25'h1;
			end else begin
				cnt_next = `MTPCS_C_WP;
				state_next = S_WLOW;
			end
		end
		S_WAIT: begin
			if (cnt_reg > 25'h1) begin
				cnt_next = cnt_reg - 25'h1;
			end else if (doRead) begin
				// sync stages eat two cycles of the access window
				cnt_next = `MTPCS_C_RDWIN;
				state_next = S_RLOW;
			end else begin
				state_next = S_FINISH;
			end
		end
		S_RLOW: begin
			if (cnt_reg > 25'h1) begin
				cnt_next = cnt_reg - 25'h1;
			end else begin
				state_next = S_FINISH;
			end
		end
		S_FINISH: begin
			state_next = S_IDLE;
		end
		default: begin
			state_next = S_IDLE;
		end
		endcase
	end

	// ---------------------------------------------------------------
	// registers and pins
	// ---------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (!nrst) begin
			state_reg <= S_IDLE;
			cnt_reg <= 25'h0;
			step_reg <= 2'h0;
			op_reg <= `MTPCS_OP_READMODE;
			addr_reg <= 18'h0;
			data_reg <= 8'h0;
			opBusy <= 1'b0;
			opDone <= 1'b0;
			opResult <= 8'h0;
			addressBus <= 18'h0;
			dataBusOut <= 8'h0;
			dataBusOe <= 1'b0;
			chipEn_n <= 1'b1;
			outEn_n <= 1'b1;
			writeEn_n <= 1'b1;
			highVoltageLevel <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			step_reg <= step_next;
			op_reg <= op_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			opBusy <= (state_next != S_IDLE);
			opDone <= (state_reg == S_FINISH);
			// sample synced data as the read window closes
			if (state_reg == S_RLOW && cnt_reg == 25'h1) begin
				opResult <= dataSync;
			end
			highVoltageLevel <= (state_next != S_IDLE);
			chipEn_n <= !(state_next == S_WLOW || state_next == S_RLOW ||
				state_next == S_HOLD || state_next == S_WHIGH);
			writeEn_n <= (state_next != S_WLOW);
			outEn_n <= (state_next != S_RLOW);
			dataBusOe <= (state_next == S_WLOW || state_next == S_HOLD);
			dataBusOut <= cmdByte;
			addressBus <= cycAddr;
		end
	end
endmodule // mtpcs_host
`default_nettype wire

/* test/mtpcs_host_chk.sv */
// Purpose: pin timing checks for the EPROM host
// Assumes: 200 MHz ref_clk
// Notes: sees host ports only
`timescale 1ns/1ps
`default_nettype none
module mtpcs_host_chk #(parameter int WR_CYC = 20) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic opStart,
	input wire logic [2:0] opCode,
	input wire logic opBusy,
	input wire logic [17:0] addressBus,
	input wire logic [7:0] dataBusOut,
	input wire logic dataBusOe,
	input wire logic chipEn_n,
	input wire logic outEn_n,
	input wire logic writeEn_n,
	input wire logic highVoltageLevel
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// saturates so a read long after any write never fires
	int weGap_reg;
	always @(posedge ref_clk)
		if (!nrst || !writeEn_n) weGap_reg <= nrst ? 0 : WR_CYC;
		else if (weGap_reg < WR_CYC) weGap_reg <= weGap_reg + 1;
	vpp_setup_a: assert property (
		$fell(chipEn_n) |-> $past(highVoltageLevel, 200))
		else $error("chip enable without supply lead");
	we_pulse_a: assert property (
		$fell(writeEn_n) |-> ##1 (!writeEn_n && $stable(addressBus))[*8]
		##1 !writeEn_n) else $error("write pulse short");
	data_hold_a: assert property (
		$rose(writeEn_n) |-> (dataBusOe && $stable(dataBusOut))[*2])
		else $error("data hold broken");
	data_setup_a: assert property (
		$rose(writeEn_n) |-> $past(dataBusOe, 8))
		else $error("data setup broken");
	we_gap_a: assert property (
		$rose(writeEn_n) |-> writeEn_n[*4]) else $error("write gap short");
	read_wait_a: assert property (
		$fell(outEn_n) |-> weGap_reg >= WR_CYC)
		else $error("read too soon after write");
	no_clash_a: assert property (
		dataBusOe |-> outEn_n) else $error("data bus clash");
	busy_take_a: assert property (
		opStart && !opBusy && opCode != 3'h7 |=> opBusy)
		else $error("start not taken");
	bad_code_a: assert property (
		opStart && !opBusy && opCode == 3'h7 |=> !opBusy)
		else $error("code 7 taken");
endmodule // mtpcs_host_chk
bind mtpcs_host mtpcs_host_chk #(.WR_CYC(WR_CYC)) chk (.ref_clk, .nrst,
	.opStart, .opCode, .opBusy, .addressBus, .dataBusOut, .dataBusOe,
	.chipEn_n, .outEn_n, .writeEn_n, .highVoltageLevel);
`default_nettype wire

/* test/mtpcs_dev_model.sv */
// Purpose: behavioural EPROM in command mode
// Assumes: only low 8 address bits decoded
// Notes: released data pins show the inverted last byte
`timescale 1ns/1ps
`default_nettype none
module mtpcs_dev_model (
	input wire logic chipEn_n,
	input wire logic outEn_n,
	input wire logic writeEn_n,
	input wire logic highVoltageLevel,
	input wire logic [17:0] addressBus,
	input wire logic [7:0] dataBusOut,
	output logic [7:0] dataBusIn
);
	logic [7:0] mem [0:255];
	logic [17:0] aLat, pa, ra;
	logic [2:0] st = 3'h0;
	initial dataBusIn = 8'h5a;
	always @(negedge writeEn_n)
		if (!chipEn_n && highVoltageLevel) aLat = addressBus;
	always @(posedge writeEn_n)
		if (!chipEn_n && highVoltageLevel) begin
			if (st == 3'h3) begin
				mem[aLat[7:0]] = dataBusOut;
				pa = aLat;
				st = 3'h0;
			end else if (st == 3'h1 && dataBusOut == 8'h20) begin
				foreach (mem[i]) mem[i] = 8'hff;
				st = 3'h0;
			end else case (dataBusOut)
				8'h00: st = 3'h0;
				8'h20: st = 3'h1;
				8'ha0: begin
					ra = aLat;
					st = 3'h2;
				end
				8'hc0: begin
					ra = pa;
					st = 3'h2;
				end
				8'h40: st = 3'h3;
				8'hff: st = (st == 3'h4) ? 3'h0 : 3'h4;
				default: ;
			endcase
		end
	always @(chipEn_n or outEn_n)
		if (!chipEn_n && !outEn_n)
			dataBusIn = (st == 3'h2) ? mem[ra[7:0]] : mem[addressBus[7:0]];
		else
			dataBusIn = ~dataBusIn;
endmodule // mtpcs_dev_model
`default_nettype wire

/* test/mtpcs_host_bench.sv */
// Purpose: self-checking bench for the EPROM host
// Assumes: shortened wait counts
// Notes: device side is a behavioural model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("Error %s expected %h seen %h", n, e, g); \
	end \
end
module mtpcs_host_bench;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic opStart = 1'b0;
	logic [2:0] opCode = 3'h0;
	logic [17:0] opAddr = 18'h0;
	logic [7:0] opData = 8'h0;
	logic opBusy, opDone, dataBusOe, chipEn_n, outEn_n, writeEn_n, vpp;
	logic [7:0] opResult, dataBusOut, dataBusIn;
	logic [17:0] addressBus;
	int n_fail = 0;
	int cmp_count = 0;
	always #2.5 ref_clk = ~ref_clk;
	mtpcs_host #(.ERASE_CYC(25'h32), .PROG_CYC(25'h14), .WR_CYC(25'h14)) DUT (
		.ref_clk, .nrst, .opStart, .opCode, .opAddr, .opData, .opBusy,
		.opDone, .opResult, .addressBus, .dataBusOut, .dataBusOe,
		.dataBusIn, .chipEn_n, .outEn_n, .writeEn_n, .highVoltageLevel(vpp));
	mtpcs_dev_model dev (.chipEn_n, .outEn_n, .writeEn_n,
		.highVoltageLevel(vpp), .addressBus, .dataBusOut, .dataBusIn);
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic run(input logic [2:0] c, input logic [17:0] a,
		input logic [7:0] d);
		int i;
		opCode = c;
		opAddr = a;
		opData = d;
		opStart = 1'b1;
		@(negedge ref_clk);
		opStart = 1'b0;
		for (i = 0; i < 9000 && opDone !== 1'b1; i++)
			@(negedge ref_clk);
		if (i == 9000) begin
			n_fail++;
			give_verdict();
		end
		@(negedge ref_clk);
	endtask
	task automatic t_prog();
		run(3'h5, 18'h0, 8'h0);
		run(3'h3, 18'h12, 8'h3c);
		run(3'h4, 18'h0, 8'h0);
		`CHK("program verify", 8'h3c, opResult)
		$display("test program done");
	endtask
	task automatic t_read();
		run(3'h3, 18'h21, 8'h96);
		run(3'h4, 18'h0, 8'h0);
		`CHK("second verify", 8'h96, opResult)
		// device now reads back 21h, the 00H read command brings plain reads back
		run(3'h0, 18'h0, 8'h0);
		run(3'h6, 18'h12, 8'h0);
		`CHK("array read", 8'h3c, opResult)
		$display("test read done");
	endtask
	task automatic t_erase();
		run(3'h1, 18'h0, 8'h0);
		run(3'h2, 18'h12, 8'h0);
		`CHK("erase verify", 8'hff, opResult)
		run(3'h3, 18'h34, 8'ha5);
		run(3'h4, 18'h12, 8'h0);
		`CHK("verify latched address", 8'ha5, opResult)
		run(3'h2, 18'h34, 8'h0);
		`CHK("erase check address", 8'ha5, opResult)
		$display("test erase done");
	endtask
	task automatic t_bad();
		opCode = 3'h7;
		opStart = 1'b1;
		@(negedge ref_clk);
		opStart = 1'b0;
		@(negedge ref_clk);
		`CHK("busy on code 7", 1'b0, opBusy)
		$display("test refused code done");
	endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		nrst = 1'b1;
		t_prog();
		t_read();
		t_erase();
		t_bad();
		give_verdict();
	end
endmodule // mtpcs_host_bench
`default_nettype wire
